// ### tnl_link.sv
`timescale 1ns/100ps
`default_nettype none
// Triggered nibble output link, device end.
module tnl_link
  import tnl_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  input  wire logic [1:0]  op_mode_in,
  input  wire logic [1:0]  sensor_bus_address_in,
  input  wire logic [1:0]  nibble_count_code_in,
  input  wire logic [3:0]  unit_tick_divider_in,
  input  wire logic [15:0] field_value_in,
  input  wire logic signed [8:0] temp_celsius_in,
  input  wire logic        ov_resume_in,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe_out,
  output logic             sample_strobe_out,
  output logic [1:0]       range_select_out
);
  // ----------------------------------------------------------
  // State and helpers.
  // ----------------------------------------------------------
  typedef struct packed {
    tnl_state_e  st;    // Sequencer state.
    logic [7:0]  tcnt;  // Ticks into the current interval.
    logic [7:0]  len;   // Length of the current interval.
    logic [7:0]  lcnt;  // Ticks since the master falling edge.
    logic [2:0]  idx;   // Nibble index, zero is status.
    logic [23:0] pay;   // Data nibbles still to send.
    logic [3:0]  nib;   // Nibble being sent.
    logic [3:0]  crc;   // Running checksum.
    logic        first; // First frame after reset.
    logic        ovp;   // Overvoltage recovery pending.
    logic [1:0]  rng;   // Range reported in the status nibble.
    logic [1:0]  rngn;  // Range requested by the master.
    logic [1:0]  hit;   // Decoded range or address.
    logic [9:0]  wcnt;  // Cycle counter for quiet times.
    logic        oe;    // Line driven low.
    logic        smp;   // Sample strobe.
  } tnl_core_s;

  tnl_core_s  q;       // Registered state.
  tnl_core_s  d;       // Next state.
  logic       restart; // Realign the unit tick.
  logic       ok;      // Master low time decoded.
  logic [1:0] code;    // Decoded range or address.
  logic [3:0] stat;    // Status nibble.
  logic [7:0] tcode;   // Temperature code.
  tnl_mode_e  mode;    // Active operating mode.
  tnl_ut_t    trig;    // Trigger time for the mode.

  tnl_tick_if tk ();

  tnl_tick_gen u_tick (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .ce_in   (ce_in),
    .tk      (tk)
  );

  assign tk.div     = unit_tick_divider_in; // RQ17
  assign tk.restart = restart;

  // Interval length for a nibble value.
  function automatic logic [7:0] nib_len(input logic [3:0] n);
    nib_len = NIB_UT + 8'(n); // RQ6
  endfunction : nib_len

  // Saturating tick counter step.
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction : sat_inc

  // Number of data nibbles for a frame code.
  function automatic logic [2:0] nib_count(input logic [1:0] f);
    unique case (f) // RQ7
      2'h0: nib_count = 3'h6;
      2'h1: nib_count = 3'h4;
      2'h2: nib_count = 3'h5;
      2'h3: nib_count = 3'h3;
    endcase
  endfunction : nib_count

  // ----------------------------------------------------------
  // Master pulse decoding.
  // ----------------------------------------------------------
  // Maps the master low time onto a window of the active mode.
  always_comb begin
    mode  = tnl_mode(op_mode_in); // RQ1
    ok    = 1'b0;
    code  = 2'h0;
    trig  = TRIG_SYN;
    unique case (mode)
      MODE_SYNC: begin
        ok = (q.lcnt >= SYN_MIN) && (q.lcnt <= SYN_MAX);
      end
      MODE_RNG: begin
        trig = TRIG_RNG;
        for (int i = 0; i < 3; i++) begin
          if (q.lcnt >= RNG_MIN[i] && q.lcnt <= RNG_MAX[i]) begin
            ok   = 1'b1;
            code = RNG_CODE[i];
          end
        end
      end
      MODE_ADR: begin
        trig = TRIG_ADR;
        for (int i = 0; i < 4; i++) begin
          if (q.lcnt >= ADR_MIN[i] && q.lcnt <= ADR_MAX[i]) begin
            ok   = 1'b1;
            code = 2'(i);
          end
        end
        ok = ok && (code == sensor_bus_address_in); // RQ20
      end
    endcase
  end

  // Status nibble and temperature code at the sample instant.
  always_comb begin
    stat[1:0] = (mode == MODE_ADR) ? sensor_bus_address_in
                                   : q.rng; // RQ2 RQ13
    stat[2]   = q.ovp;   // RQ14
    stat[3]   = q.first; // RQ15
    tcode     = 8'(9'(temp_celsius_in) + TEMP_OFS); // RQ12
  end

  // ----------------------------------------------------------
  // Frame sequencer.
  // ----------------------------------------------------------
  // Walks trigger, sync, nibbles and end pulse, one tick at a time.
  always_comb begin
    d       = q;
    restart = 1'b0;
    d.smp   = 1'b0;
    if (ov_resume_in) begin
      d.ovp = 1'b1;
    end
    unique case (q.st)
      ST_IDLE: begin
        // A falling edge from the master starts a trigger.
        if (!line_in) begin
          d.st    = ST_MLOW;
          d.lcnt  = 8'h00;
          restart = 1'b1;
        end
      end
      ST_MLOW: begin
        if (tk.tick) begin
          d.lcnt = sat_inc(q.lcnt);
        end
        if (line_in) begin
          if (ok) begin
            d.st  = ST_TRIG;
            d.hit = code;
            if (mode == MODE_RNG) begin
              d.rngn = code;
            end
          end else begin
            d.st   = ST_REARM; // RQ19
            d.wcnt = 10'h000;
          end
        end
      end
      ST_TRIG: begin
        // Sync starts a fixed time after the master falling edge.
        if (tk.tick) begin
          d.lcnt = sat_inc(q.lcnt);
          if (sat_inc(q.lcnt) == trig) begin
            d.st    = ST_SYNC; // RQ5
            d.tcnt  = 8'h00;
            d.len   = SYNC_UT;
            d.oe    = 1'b1;
            d.smp   = 1'b1;    // RQ11
            restart = 1'b1;
            d.idx   = 3'h0;
            d.nib   = stat;
            d.crc   = tnl_crc(CRC_SEED, stat); // RQ18
            d.first = 1'b0;
            d.ovp   = ov_resume_in;
            unique case (nibble_count_code_in) // RQ22
              2'h0: d.pay = {field_value_in, tcode};
              2'h1: d.pay = {field_value_in, 8'h00};
              2'h2: d.pay = {field_value_in[15:4], tcode, 4'h0};
              2'h3: d.pay = {field_value_in[15:4], 12'h000};
            endcase
          end
        end
      end
      ST_SYNC, ST_NIB, ST_ENDP: begin
        if (q.st == ST_ENDP) begin
          d.wcnt = q.wcnt + 10'h001;
        end
        if (tk.tick) begin
          if (q.tcnt != q.len - 8'h01) begin
            d.tcnt = q.tcnt + 8'h01;
            d.oe   = (q.tcnt + 8'h01) < LOW_UT; // RQ4
          end else begin
            // Next falling edge closes this interval.
            d.tcnt = 8'h00;
            d.oe   = 1'b1; // RQ3
            if (q.st == ST_SYNC) begin
              d.st  = ST_NIB;
              d.len = nib_len(q.nib);
            end else if (q.st == ST_ENDP) begin
              d.st = ST_HOLD;
              d.oe = 1'b0;
            end else if (q.idx < nib_count(nibble_count_code_in)) begin
              d.nib = q.pay[23:20];
              d.pay = {q.pay[19:0], 4'h0};
              d.crc = tnl_crc(q.crc, q.pay[23:20]); // RQ9
              d.idx = q.idx + 3'h1;
              d.len = nib_len(q.pay[23:20]);
            end else if (q.idx == nib_count(nibble_count_code_in)) begin
              d.nib = q.crc;
              d.idx = q.idx + 3'h1;
              d.len = nib_len(q.crc);
            end else begin
              d.st   = ST_ENDP; // RQ8
              d.len  = LOW_UT;
              d.wcnt = 10'h000;
              d.rng  = q.rngn;  // RQ21
            end
          end
        end
      end
      ST_HOLD: begin
        // Quiet time counted from the end pulse falling edge.
        d.wcnt = q.wcnt + 10'h001;
        if (q.wcnt >= 10'(GUARD_CYC - 1)) begin
          d.st = ST_IDLE; // RQ10
        end
      end
      ST_REARM: begin
        // Counts only while the line stays released.
        d.wcnt = line_in ? q.wcnt + 10'h001 : 10'h000;
        if (line_in && q.wcnt >= 10'(REARM_CYC - 1)) begin
          d.st = ST_IDLE; // RQ19
        end
      end
    endcase
  end

  // Registers the state; clock enable freezes it.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.first <= 1'b1;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------
  assign line_out          = 1'b0; // Open drain pulls low only.
  assign line_oe_out       = q.oe;
  assign sample_strobe_out = q.smp;
  assign range_select_out  = q.rngn;

  // ----------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  a_sync_trig_time: // RQ1
    assert property ((q.st == ST_TRIG) && ce_in && tk.tick && !op_mode_in[1]
                     && (q.lcnt == TRIG_SYN - 8'h01) |=> q.st == ST_SYNC)
    else $error("sync trigger time wrong");
  a_low_phase_end: // RQ4
    assert property (ce_in && tk.tick && q.oe && (q.st != ST_ENDP)
                     && (q.tcnt == LOW_UT - 8'h01) |=> !q.oe)
    else $error("low phase not three ticks");
  a_sync_len: // RQ5
    assert property ((q.st == ST_SYNC) |-> q.len == SYNC_UT)
    else $error("sync period length wrong");
  a_nibble_len: // RQ6
    assert property ((q.st == ST_NIB) |-> q.len == NIB_UT + 8'(q.nib))
    else $error("nibble length wrong");
  a_end_to_hold: // RQ8
    assert property ((q.st == ST_ENDP) && ce_in && tk.tick
                     && (q.tcnt == LOW_UT - 8'h01)
                     |=> (q.st == ST_HOLD) && !q.oe)
    else $error("end pulse did not release line");
  a_guard_wait: // RQ10
    assert property ((q.st == ST_HOLD) && (d.st == ST_IDLE) && ce_in
                     |-> q.wcnt >= 10'(GUARD_CYC - 1))
    else $error("trigger accepted too early");
  a_reset_flag: // RQ15
    assert property (q.smp && ce_in |-> !q.first
                     && (q.nib[3] == $past(q.first)))
    else $error("reset flag wrong");
  a_addr_match: // RQ20
    assert property ((q.st == ST_TRIG) && (mode == MODE_ADR)
                     |-> q.hit == sensor_bus_address_in)
    else $error("answered foreign address");
  a_crc_seed: // RQ18
    assert property (q.smp |-> q.crc == tnl_crc(CRC_SEED, q.nib))
    else $error("checksum seed wrong");
endmodule : tnl_link
`default_nettype wire

// ### tnl_master.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Master model: triggers frames and decodes edge intervals.
// ------------------------------------------------------------
module tnl_master (
  input  wire logic        mclk_in,
  input  wire logic        dev_pull_in,
  input  wire logic [3:0]  div_in,
  output logic             line_out,
  output logic             done_out,
  output logic [52:0]      frame_out
);
  localparam logic [52:0] ACC0 = 53'h0010_0000_0000; // Lows-ok set.
  logic        mpull  = 1'b0;  // Master pulls the wire low.
  time         t_fall = 0;     // Time of the latest falling edge.
  int          n_edge = 0;     // Device edges seen in this frame.
  int          ut;             // Unit tick in ns.
  logic [52:0] acc    = ACC0;  // Frame being decoded.

  // Open-drain wire with pull-up: low while either party pulls.
  assign line_out = !(mpull || dev_pull_in);
  assign ut       = (int'(div_in) + 16) * 125;

  // Rounds a span to whole unit ticks.
  function automatic int rnd(input time dt);
    rnd = int'((dt + ut / 2) / ut);
  endfunction : rnd

  // Low pulse of whole cycles, about low_ut and a half ticks long.
  task automatic trigger(input int low_ut);
    @(negedge mclk_in);
    mpull  = 1'b1;
    t_fall = $time;
    repeat ((low_ut * ut + ut / 2) / 100) @(negedge mclk_in);
    mpull = 1'b0;
  endtask : trigger

  // Each device falling edge closes one interval of the frame.
  always @(posedge dev_pull_in) begin
    if (n_edge == 0) begin
      acc[52:45] = 8'(rnd($time - t_fall));
    end else if (n_edge == 1) begin
      acc[44:37] = 8'(rnd($time - t_fall));
    end else begin
      acc[35:32] = acc[35:32] + 4'h1;
      acc[31:0]  = {acc[27:0], 4'(rnd($time - t_fall) - 12)};
    end
    n_edge++;
    t_fall = $time;
  end

  // Every low phase the device makes must last three ticks.
  // Only releases inside a frame count: the wire settling out of
  // reset is no low phase of the device.
  always @(negedge dev_pull_in) begin
    if (n_edge > 0 && rnd($time - t_fall) != 3) begin
      acc[36] = 1'b0;
    end
  end

  // A quiet wire for thirty ticks after the latest device edge closes
  // the frame once the status edge is in; the sync period alone is longer than that.
  always @(posedge mclk_in) begin
    done_out <= 1'b0;
    if (n_edge > 1 && $time - t_fall > 30 * ut) begin
      frame_out <= acc;
      done_out  <= 1'b1;
      n_edge = 0;
      acc    = ACC0;
    end
  end
endmodule : tnl_master
`default_nettype wire

// ### tnl_pkg.sv
// Operation
// RQ1: Mode field picks synchronous, range or address.
// RQ2: Bus address used only in address mode.
// RQ3: Nibble value is gap between falling edges.
// RQ4: Each edge starts with three-tick low phase.
// RQ5: Trigger starts 56-tick sync, sample taken.
// RQ6: Nibbles last twelve ticks plus value.
// RQ7: Frame code sets data nibble count.
// RQ8: End pulse after checksum returns line idle.
// RQ9: Checksum covers status and data nibbles.
// RQ10: New trigger accepted 90 us after end.
// RQ11: Sample at sync start, computed anew.
// RQ12: Temperature code is Celsius plus 55.
// RQ13: Status bits 0-1 carry range or address.
// RQ14: Status bit 2 flags overvoltage recovery once.
// RQ15: Status bit 3 flags first frame after reset.
// RQ16: Unit tick is (divider+16) internal clocks.
// RQ17: Divider is four bits, resets to eight; the link takes it from unit_tick_divider_in and holds no reset value.
// RQ18: Checksum polynomial x4+x3+x2+1, seed 0101.
// RQ19: Overlong trigger ignored, rearm 30 us later.
// RQ20: Address mode answers only matching address.
// RQ21: Range change shows one frame late.
// RQ22: Data sent MSB first, field before temperature.
`default_nettype none
package tnl_pkg;
  // ----------------------------------------------------------
  // Timing constants.
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;   // System clock period.
  localparam int RC_PERIOD_NS  = 125;   // Internal tick clock period.
  localparam int DIV_BASE      = 16;    // Added to the divider.
  localparam logic [3:0] DIV_RST = 4'h8; // Divider reset value.
  localparam int GUARD_NS  = 90000;     // Quiet time after end pulse.
  localparam int REARM_NS  = 30000;     // Wait after overlong trigger.
  localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REARM_CYC = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [7:0] tnl_ut_t;         // A count of unit ticks.
  localparam tnl_ut_t LOW_UT   = 8'h03; // Low phase of each edge.
  localparam tnl_ut_t SYNC_UT  = 8'h38; // Sync period length.
  localparam tnl_ut_t NIB_UT   = 8'h0C; // Nibble base length.
  localparam tnl_ut_t TRIG_SYN = 8'h0D; // Trigger time, synchronous.
  localparam tnl_ut_t TRIG_RNG = 8'h38; // Trigger time, range mode.
  localparam tnl_ut_t TRIG_ADR = 8'h5A; // Trigger time, address mode.
  localparam tnl_ut_t SYN_MIN  = 8'h01; // Master low window, sync mode.
  localparam tnl_ut_t SYN_MAX  = 8'h04;
  // Master low windows per range and per address.
  localparam tnl_ut_t RNG_MIN [3] = '{8'h01, 8'h09, 8'h18};
  localparam tnl_ut_t RNG_MAX [3] = '{8'h05, 8'h0F, 8'h27};
  localparam logic [1:0] RNG_CODE [3] = '{2'h0, 2'h1, 2'h3};
  localparam tnl_ut_t ADR_MIN [4] = '{8'h09, 8'h13, 8'h23, 8'h3D};
  localparam tnl_ut_t ADR_MAX [4] = '{8'h0C, 8'h17, 8'h28, 8'h43};

  localparam logic [3:0] CRC_SEED = 4'h5; // Checksum seed.
  localparam logic [3:0] CRC_POLY = 4'hD; // x4 term implied.
  localparam logic [8:0] TEMP_OFS = 9'h037; // Celsius offset.

  // ----------------------------------------------------------
  // Modes and states.
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_RNG  = 2'b10,
    MODE_ADR  = 2'b11
  } tnl_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MLOW  = 3'b001,
    ST_TRIG  = 3'b010,
    ST_SYNC  = 3'b011,
    ST_NIB   = 3'b100,
    ST_ENDP  = 3'b101,
    ST_HOLD  = 3'b110,
    ST_REARM = 3'b111
  } tnl_state_e;

  // Upper bit clear means synchronous whatever the lower bit.
  function automatic tnl_mode_e tnl_mode(input logic [1:0] m);
    tnl_mode = !m[1] ? MODE_SYNC : (m[0] ? MODE_ADR : MODE_RNG); // RQ1
  endfunction : tnl_mode

  // One checksum step over a nibble, most significant bit first.
  function automatic logic [3:0] tnl_crc(input logic [3:0] c,
                                         input logic [3:0] n);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 3; i >= 0; i--) begin
      fb = r[3] ^ n[i];
      r  = {r[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0); // RQ18
    end
    tnl_crc = r;
  endfunction : tnl_crc
endpackage : tnl_pkg
`default_nettype wire

// ### tnl_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
// Unit tick generator: a phase accumulator in nanoseconds.
module tnl_tick_gen
  import tnl_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  tnl_tick_if.gen   tk
);
  // ----------------------------------------------------------
  // State.
  // ----------------------------------------------------------
  typedef struct packed {
    logic [11:0] acc;  // Elapsed time within the tick.
    logic        tick; // Tick pulse.
  } tnl_gen_s;

  tnl_gen_s    q;     // Registered state.
  tnl_gen_s    d;     // Next state.
  logic [11:0] limit; // Unit tick length in ns.
  logic [12:0] sum;   // Accumulator after this cycle.

  // Adds one clock period; a tick falls each time a unit passes.
  always_comb begin
    d     = q;
    limit = 12'((13'(tk.div) + 13'(DIV_BASE)) * 13'(RC_PERIOD_NS)); // RQ16
    sum   = 13'(q.acc) + 13'(CLK_PERIOD_NS);
    d.tick = 1'b0;
    if (tk.restart) begin
      d.acc = 12'h000;
    end else if (sum >= 13'(limit)) begin
      d.acc  = 12'(sum - 13'(limit));
      d.tick = 1'b1;
    end else begin
      d.acc = sum[11:0];
    end
  end

  // Registers the state; clock enable freezes it.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;
endmodule : tnl_tick_gen
`default_nettype wire

// ### tnl_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
// Carries the divider, restart and unit tick between modules.
interface tnl_tick_if;
  logic [3:0] div;      // Unit tick divider.
  logic       restart;  // Realigns the tick phase.
  logic       tick;     // One-cycle unit tick pulse.
  modport gen  (input div, input restart, output tick);
  modport user (output div, output restart, input tick);
endinterface : tnl_tick_if
`default_nettype wire

// ### triggered_nibble_output_link_tb.sv
`timescale 1ns/100ps
`default_nettype none
module triggered_nibble_output_link_tb;
  // ----------------------------------------------------------
  // Stimulus and bookkeeping.
  // ----------------------------------------------------------
  logic              mclk_in    = 1'b0;      // System clock.
  logic              nrst_in    = 1'b0;      // Reset, active low.
  logic [1:0]        op_mode    = 2'h0;      // Operating mode.
  logic [1:0]        bus_addr   = 2'h2;      // Programmed address.
  logic [1:0]        fcode      = 2'h0;      // Frame code.
  logic [3:0]        div        = 4'h8;      // Divider reset value.
  logic [15:0]       field      = 16'h1234;  // Field value.
  logic signed [8:0] temp       = 9'h019;    // Celsius.
  logic              ov         = 1'b0;      // Overvoltage ended.
  wire logic         line;                   // Wire level.
  logic              lo;                     // Open-drain data level.
  logic              oe;                     // Device pulls low.
  logic              strobe;                 // Sample instant.
  logic [1:0]        rsel;                   // Requested range.
  logic              done;                   // Frame decoded.
  logic [52:0]       frame;                  // Decoded frame.
  logic [54:0]       exp_q[$];               // Expected frames.
  logic [54:0]       exp_w;                  // Oldest expectation.
  logic [1:0]        cur_rng    = 2'h0;      // Range in status.
  logic              first_f    = 1'b1;      // First frame pending.
  logic              ov_f       = 1'b0;      // Overvoltage pending.
  int                seed       = 32'h4136_039c;
  int                err_count  = 0;
  int                n_compared = 0;

  // Clock of 100 ns period.
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  tnl_link u_dut (
    .mclk_in               (mclk_in),
    .nrst_in               (nrst_in),
    .ce_in                 (1'b1),
    .op_mode_in            (op_mode),
    .sensor_bus_address_in (bus_addr),
    .nibble_count_code_in  (fcode),
    .unit_tick_divider_in  (div),
    .field_value_in        (field),
    .temp_celsius_in       (temp),
    .ov_resume_in          (ov),
    .line_in               (line),
    .line_out              (lo),
    .line_oe_out           (oe),
    .sample_strobe_out     (strobe),
    .range_select_out      (rsel)
  );

  tnl_master u_master (
    .mclk_in     (mclk_in),
    .dev_pull_in (oe),
    .div_in      (div),
    .line_out    (line),
    .done_out    (done),
    .frame_out   (frame)
  );

  // ----------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------
  // Prints the verdict and stops.
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // One checksum step, most significant bit first.
  function automatic logic [3:0] crc_step(input logic [3:0] c,
                                          input logic [3:0] x);
    logic [3:0] r;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      r = {r[2:0], 1'b0} ^ ((r[3] ^ x[b]) ? 4'hD : 4'h0);
    end
    return r;
  endfunction : crc_step

  // Notes the expected frame, triggers it and waits for its end.
  // A trig_ut of zero means the trigger must be refused.
  task automatic send(input logic [1:0] mode, input int low_ut,
                      input logic [1:0] fc, input int trig_ut,
                      input logic [1:0] req);
    logic [23:0] dv;
    logic [3:0]  st;
    logic [3:0]  crc;
    logic [1:0]  rng;
    int          n;
    int          k;
    repeat (400) @(negedge mclk_in);
    op_mode = mode;
    fcode   = fc;
    case (fc)
      2'h0: dv = {field, 8'(temp + 9'sh037)};
      2'h1: dv = {8'h00, field};
      2'h2: dv = {4'h0, field[15:4], 8'(temp + 9'sh037)};
      default: dv = {12'h000, field[15:4]};
    endcase
    n   = (fc == 2'h0) ? 6 : (fc == 2'h1) ? 4 : (fc == 2'h2) ? 5 : 3;
    rng = (mode == 2'b10) ? req : cur_rng;
    st  = {first_f, ov_f, (mode == 2'b11) ? bus_addr : cur_rng};
    crc = crc_step(4'h5, st);
    for (k = n - 1; k >= 0; k--) begin
      crc = crc_step(crc, dv[4*k+:4]);
    end
    if (trig_ut != 0) begin
      exp_q.push_back({rng, 8'(trig_ut), 8'h38, 1'b1, 4'(n + 2),
                       (32'(st) << (4 * n + 4)) | (32'(dv) << 4) | 32'(crc)});
    end
    u_master.trigger(low_ut);
    if (trig_ut == 0) begin
      repeat (1000) @(negedge mclk_in);
      return;
    end
    for (k = 0; k < 4000 && strobe !== 1'b1; k++) @(negedge mclk_in);
    n_compared++;
    if (strobe !== 1'b1 || lo !== 1'b0) begin
      err_count++;
      $display("BAD %0t %h %h", $time, {strobe, lo}, 2'h2);
    end
    // New values after the sample instant must not reach this frame.
    field   = 16'($random(seed));
    temp    = 9'(($random(seed) & 255) - 55);
    first_f = 1'b0;
    ov_f    = 1'b0;
    if (mode == 2'b10) begin
      cur_rng = req;
    end
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge mclk_in);
  endtask : send

  // ----------------------------------------------------------
  // Checker of decoded frames against the oldest note.
  // ----------------------------------------------------------
  always @(negedge mclk_in) begin
    if (done === 1'b1) begin
      // An all-ones note stands for a frame that nobody asked for.
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
      n_compared++;
      if ({rsel, frame} !== exp_w) begin
        err_count++;
        $display("BAD %0t %h %h", $time, {rsel, frame}, exp_w);
      end
    end
  end

  // ----------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(negedge mclk_in);
    nrst_in = 1'b1;
    send(2'b00, 2, 2'h0, 13, 2'h0);
    // Shorter ticks until the last frame keep the run brief.
    div = 4'h0;
    for (int i = 1; i < 4; i++) begin
      send(2'b01, 2, 2'(i), 13, 2'h0);
    end
    // Trigger inside the quiet time after the end pulse.
    u_master.trigger(2);
    repeat (3000) @(negedge mclk_in);
    send(2'b00, 8, 2'h0, 0, 2'h0);
    ov = 1'b1;
    @(negedge mclk_in);
    ov   = 1'b0;
    ov_f = 1'b1;
    send(2'b10, 12, 2'h2, 56, 2'h1);
    send(2'b10, 31, 2'h3, 56, 2'h3);
    send(2'b10, 3, 2'h1, 56, 2'h0);
    send(2'b11, 10, 2'h0, 0, 2'h0);
    send(2'b11, 37, 2'h0, 90, 2'h0);
    div = 4'($random(seed));
    send(2'b00, 2, 2'h3, 13, 2'h0);
    repeat (100) @(negedge mclk_in);
    n_compared++;
    if (exp_q.size() != 0) begin
      err_count++;
      $display("BAD %0t %h %h", $time, exp_q.size(), 0);
    end
    complete_run();
  end

  // Watchdog: the sequence needs well under this many cycles.
  initial begin
    repeat (100000) @(posedge mclk_in);
    err_count++;
    complete_run();
  end
endmodule : triggered_nibble_output_link_tb
`default_nettype wire
